// ==== verilog/fp_pkg.sv ====
// Purpose: shared constants for the front panel step sequencer
// Assumes: 125 MHz system clock, 32-bit register bus
// Notes: times are kept in their own unit, cycle counts derived
package fp_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int DEBOUNCE_US = 1000;
	localparam int MWRITE_US = 100;
	localparam int SLOW_MAX_MS = 5000;
	localparam int DRV_ON_NS = 50;
	localparam int MEM_SETUP_NS = 100;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int MWRITE_CYC = (MWRITE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SLOW_MAX_CYC = SLOW_MAX_MS * (1000000 / CLK_NS);
	localparam int DRV_ON_CYC = (DRV_ON_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (MEM_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] DRV_ON = 5'(DRV_ON_CYC);
	localparam logic [4:0] DRV_MAX = 5'(DRV_ON_CYC + SETUP_CYC);

	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] SLOW_PERIOD_OFS = 8'h04;
	localparam logic [7:0] CTRL_OFS = 8'h08;
	localparam int CTRL_LOCK_BIT = 0;
	localparam int ST_RUN_BIT = 0;
	localparam int ST_XRDY_BIT = 1;
	localparam int ST_SS_BIT = 2;
	localparam int ST_MW_BIT = 3;
	localparam int ST_DEB_BIT = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN, ST_STOP, ST_STEP, ST_NOP, ST_DEP, ST_REL
	} seq_state_e;
endpackage

// ==== verilog/timer_if.sv ====
// Purpose: control link between the sequencer and its interval timers
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, len is sampled with it
`timescale 1ns/1ps
interface timer_if;
	logic start;
	logic [31:0] len;
	logic busy;
	modport ctl(output start, output len, input busy);
	modport tmr(input start, input len, output busy);
endinterface

// ==== verilog/pin_sync.sv ====
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: every bit is an independent level
// Notes: only the second stage may be read
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ==== verilog/interval_timer.sv ====
// Purpose: retriggerable down counter standing in for a one-shot
// Assumes: len is at least one cycle
// Notes: a start while busy reloads the count
`timescale 1ns/1ps
module interval_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	timer_if.tmr t
);
	logic [31:0] cnt;

	assign t.busy = (cnt != 32'h0);

	// reload on start, else count down to zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0;
		end else if (t.start) begin
			cnt <= t.len;
		end else if (cnt != 32'h0) begin
			cnt <= cnt - 32'h1;
		end
	end
endmodule

// ==== verilog/front_panel_step_sequencer.sv ====
// Purpose: run/stop, single/slow step, examine-next and deposit control
// Assumes: bus pins and switches are asynchronous to clk, bus << clk
// Notes: registers over AXI4-Lite; breakpoint logic lives elsewhere
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

// Functional notes
// (RL1) xrdy high lets the processor run, low stops it.
// (RL2) run output mirrors the run/stop state.
// (RL3) raised run switch enters Run only without a breakpoint stop request.
// (RL4) stop-only manual functions are inhibited while running.
// (RL5) poc low forces Stop and drops xrdy.
// (RL6) lowered run switch stops only when m1, psync, phase one high.
// (RL7) single step only in Stop and with debounce expired.
// (RL8) step raises xrdy; next psync starts debounce and drops xrdy.
// (RL9) no further step until the ~1 ms debounce has expired.
// (RL10) slow step repeats steps at debounce expiry, 1 ms to 5 s.
// (RL11) examine-next only in Stop, executes exactly one NOP.
// (RL12) examine-next: ss low, xrdy high, zero byte driven during dbin.
// (RL13) own data drivers enabled only after ss low disabled CPU buffers.
// (RL14) next M1 psync: debounce start, ss high, xrdy low, drivers off.
// (RL15) deposit keeps processor stopped; ss low and debounce start.
// (RL16) deposit drives the low byte switches onto the data bus.
// (RL17) drivers switch on after ss falls, off before ss rises; a poc stop drops both in the same cycle.
// (RL18) after data plus setup delay, mwrite pulses about 0.1 ms.
// (RL19) at deposit debounce end ss rises, drivers off without delay.
// (RL20) deposit-type memory writes disabled in Run.
// (RL21) ss stays inactive throughout Run.
// (RL22) processor waits while xrdy low, resumes when high.
// (RL23) one-shots are realised as clock-cycle counters.
module front_panel_step_sequencer import fp_pkg::*; #(
	parameter logic [31:0] DEB_CYC = 32'(DEBOUNCE_CYC),
	parameter logic [31:0] MW_CYC = 32'(MWRITE_CYC),
	parameter logic [31:0] SLOW_MAX = 32'(SLOW_MAX_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// processor bus status pins
	input wire logic poc_n,
	input wire logic phase1,
	input wire logic psync,
	input wire logic m1,
	input wire logic dbin,
	input wire logic bkpt_req,
	// panel switches
	input wire logic run_stop_switch,
	input wire logic step_switch,
	input wire logic slow_step_switch,
	input wire logic examine_switch,
	input wire logic deposit_switch,
	input wire logic [7:0] low_byte_switches,
	// panel controls to the bus
	output logic xrdy,
	output logic run,
	output logic ss_o,
	output logic ss_oe,
	output logic [7:0] dbus_o,
	output logic dbus_oe,
	output logic mwrite
);
	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	logic [18:0] pins_s;
	logic poc_s, ph1_s, ps_s, m1_s, dbin_s, bkpt_s;
	logic run_sw, step_sw, slow_sw, exam_sw, dep_sw;
	logic [7:0] byte_s;

	pin_sync #(.W(19)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({poc_n, phase1, psync, m1, dbin, bkpt_req, run_stop_switch,
			step_switch, slow_step_switch, examine_switch,
			deposit_switch, low_byte_switches}),
		.q(pins_s)
	);

	assign {poc_s, ph1_s, ps_s, m1_s, dbin_s, bkpt_s} = pins_s[18:13];
	assign {run_sw, step_sw, slow_sw, exam_sw, dep_sw} = pins_s[12:8];
	assign byte_s = pins_s[7:0];

	// edge history of synchronised levels
	logic ps_q, step_q, exam_q, dep_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ps_q, step_q, exam_q, dep_q} <= 4'h0;
		end else begin
			{ps_q, step_q, exam_q, dep_q} <= {ps_s, step_sw, exam_sw, dep_sw};
		end
	end

	// ---------------------------------------------------------------
	// interval timers
	// ---------------------------------------------------------------
	timer_if deb ();
	timer_if mw ();

	interval_timer u_deb (
		.clk(clk),
		.rst_n(rst_n),
		.t(deb)
	);

	interval_timer u_mw (
		.clk(clk),
		.rst_n(rst_n),
		.t(mw)
	);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] slow_period;
	logic lock;
	seq_state_e state, next_state;
	logic [4:0] drv_cnt;

	// clamp a software period into the slow-step range
	function automatic logic [31:0] clamp_period(input logic [31:0] v);
		if (v < DEB_CYC) begin
			return DEB_CYC;
		end else if (v > SLOW_MAX) begin
			return SLOW_MAX;
		end
		return v;
	endfunction

	// ---------------------------------------------------------------
	// sequencer decode
	// ---------------------------------------------------------------
	wire psync_rise = ps_s & ~ps_q;
	wire stopped = (state == ST_STOP);
	// manual functions only from a quiet Stop, never from Run
	wire manual_ok = stopped & ~deb.busy & ~lock; // [RL4] [RL7] [RL20]
	// slow step retriggers on the level, single step on the edge
	wire step_go = manual_ok & ((step_sw & ~step_q) | slow_sw); // [RL10]
	wire exam_go = manual_ok & exam_sw & ~exam_q; // [RL11]
	wire dep_go = manual_ok & dep_sw & ~dep_q; // [RL15]
	wire fetch_start = m1_s & ps_s & ph1_s; // [RL6]
	wire drv_phase = (state == ST_NOP) | (state == ST_DEP);
	wire drv_on = drv_phase & (drv_cnt >= DRV_ON); // [RL13] [RL17]
	wire mw_fire = (state == ST_DEP) & (drv_cnt == DRV_MAX - 5'h1);

	// next state of the sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (~run_sw & fetch_start) begin
					next_state = ST_STOP; // [RL6]
				end
			end
			ST_STOP: begin
				if (run_sw & ~bkpt_s) begin
					next_state = ST_RUN; // [RL3]
				end else if (dep_go) begin
					next_state = ST_DEP;
				end else if (exam_go) begin
					next_state = ST_NOP;
				end else if (step_go) begin
					next_state = ST_STEP; // [RL7]
				end
			end
			ST_STEP: begin
				if (psync_rise) begin
					next_state = ST_STOP; // [RL8]
				end
			end
			ST_NOP: begin
				// the NOP fetch completes; the next fetch ends it
				if (psync_rise & m1_s) begin
					next_state = ST_REL; // [RL14]
				end
			end
			ST_DEP: begin
				if (~deb.busy & ~deb.start) begin
					next_state = ST_REL; // [RL19]
				end
			end
			ST_REL: begin
				next_state = ST_STOP;
			end
			default: begin
				next_state = ST_STOP;
			end
		endcase
		if (!poc_s) begin
			next_state = ST_STOP; // [RL5]
		end
	end

	// debounce starts at the ending psync or at deposit entry
	assign deb.start = ((state == ST_STEP) & psync_rise) // [RL8]
		| ((state == ST_NOP) & psync_rise & m1_s) // [RL14]
		| ((state == ST_STOP) & (next_state == ST_DEP)); // [RL15]
	assign deb.len = slow_sw ? slow_period : DEB_CYC; // [RL9] [RL10] [RL23]
	assign mw.start = mw_fire; // [RL18]
	assign mw.len = MW_CYC; // [RL23]

	// state and driver delay counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_STOP;
			drv_cnt <= 5'h0;
		end else begin
			state <= next_state;
			if (!drv_phase) begin
				drv_cnt <= 5'h0;
			end else if (drv_cnt != DRV_MAX) begin
				drv_cnt <= drv_cnt + 5'h1; // [RL17]
			end
		end
	end

	// ---------------------------------------------------------------
	// bus control outputs
	// ---------------------------------------------------------------
	// processor wait requests follow the next state; ss released a cycle
	// after the drivers, except on a poc stop, which drops both in one cycle
	wire next_xrdy = (next_state == ST_RUN) | (next_state == ST_STEP)
		| (next_state == ST_NOP); // [RL1] [RL12] [RL22]
	wire next_ss = (next_state == ST_NOP) | (next_state == ST_DEP)
		| (next_state == ST_REL); // [RL21]
	wire next_drv = drv_on & (next_state == state)
		& ((state == ST_DEP) | dbin_s); // [RL12] [RL19]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xrdy <= 1'b0;
			run <= 1'b0;
			ss_o <= 1'b0;
			ss_oe <= 1'b0;
			dbus_o <= 8'h00;
			dbus_oe <= 1'b0;
			mwrite <= 1'b0;
		end else begin
			xrdy <= next_xrdy; // [RL1]
			run <= (next_state == ST_RUN); // [RL2]
			ss_o <= 1'b0;
			ss_oe <= next_ss; // [RL12] [RL15]
			dbus_oe <= next_drv; // [RL13]
			dbus_o <= (state == ST_DEP) ? byte_s : 8'h00; // [RL16] [RL12]
			mwrite <= mw.busy & (state == ST_DEP); // [RL18] [RL20]
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	logic aw_got, w_got;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	assign awready = ~aw_got & ~bvalid;
	assign wready = ~w_got & ~bvalid;
	assign arready = ~rvalid;
	wire do_write = aw_got & w_got & ~bvalid;
	wire wr_slow = (aw_addr == SLOW_PERIOD_OFS);
	wire wr_ctrl = (aw_addr == CTRL_OFS);
	wire wr_hit = wr_slow | wr_ctrl | (aw_addr == STATUS_OFS);
	wire [31:0] status_word = {27'h0, deb.busy, mwrite, ss_oe, xrdy, run};
	wire rd_hit = (araddr == STATUS_OFS) | (araddr == SLOW_PERIOD_OFS)
		| (araddr == CTRL_OFS);

	// merge byte lanes into a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// write path: address and data in either order, one at a time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			slow_period <= DEB_CYC;
			lock <= 1'b0;
		end else begin
			if (awvalid & awready) begin
				aw_got <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid & wready) begin
				w_got <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				if (wr_slow) begin
					slow_period <= clamp_period(
						merge(slow_period, w_data, w_strb)); // [RL10]
				end
				if (wr_ctrl & w_strb[0]) begin
					lock <= w_data[CTRL_LOCK_BIT];
				end
			end else if (bvalid & bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read path: one cycle from address to data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid & arready) begin
			rvalid <= 1'b1;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				STATUS_OFS: rdata <= status_word;
				SLOW_PERIOD_OFS: rdata <= slow_period;
				CTRL_OFS: rdata <= {31'h0, lock};
				default: rdata <= 32'h0;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_run_lets_go: assert property (run |-> xrdy) // [RL1]
		else $error("run shown while xrdy low");
	a_run_mirror: assert property (run == (state == ST_RUN)) // [RL2]
		else $error("run output differs from state");
	a_bkpt_blocks: assert property (
		(stopped && bkpt_s && !dep_go && !exam_go && !step_go)
		|=> stopped) // [RL3]
		else $error("left stop under breakpoint request");
	a_poc_stops: assert property (!poc_s |=> (!run && !xrdy)) // [RL5]
		else $error("poc did not force stop");
	a_step_halts: assert property (
		(state == ST_STEP && psync_rise) |=> (!xrdy && deb.busy)) // [RL8]
		else $error("step did not halt at psync");
	a_step_refused: assert property (
		(stopped && deb.busy) |=> state != ST_STEP) // [RL9]
		else $error("step taken during debounce");
	a_nop_zero: assert property (
		(dbus_oe && $past(state) == ST_NOP) |-> dbus_o == 8'h00) // [RL12]
		else $error("nop byte not zero");
	a_drv_late: assert property ($rose(dbus_oe) |-> $past(ss_oe, 2)) // [RL13]
		else $error("drivers on before ss settled");
	a_dep_stopped: assert property (state == ST_DEP |=> !xrdy) // [RL15]
		else $error("processor released in deposit");
	a_mw_data: assert property ($rose(mwrite) |-> (dbus_oe && ss_oe)) // [RL18]
		else $error("mwrite without driven data");
	a_run_quiet: assert property (run |-> (!ss_oe && !mwrite)) // [RL21]
		else $error("ss or mwrite active in run");
	a_drv_early: assert property ($fell(ss_oe) |-> !$past(dbus_oe)) // [RL17]
		else $error("drivers still on as ss rose");

	c_step: cover property (state == ST_STEP ##1 state == ST_STOP);
	c_nop: cover property (state == ST_NOP ##1 state == ST_REL);
	c_dep: cover property ($fell(mwrite) ##[1:1000] state == ST_REL);
	c_run: cover property (state == ST_STOP ##1 state == ST_RUN);
endmodule

// ==== test/cpu_model.sv ====
// Purpose: processor and CPU board stand-in driving the bus status pins
// Assumes: one bus state lasts eight clk cycles, fetch and read alternate
// Notes: waits in T2 while xrdy is low, so no psync while stopped
`timescale 1ns/1ps
module cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ready from the panel
	input wire logic xrdy,
	// bus status out
	output logic psync,
	output logic phase1,
	output logic m1,
	output logic dbin
);
	logic [2:0] tick;
	logic [1:0] tst;
	logic fetch;
	// wait states are inserted in T2 for as long as ready is low
	wire hold = (tst == 2'h1) && !xrdy;
	wire adv = (tick == 3'h7) && !hold;
	// bus state sequencing; the phase clock keeps running while held
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 3'h0;
			tst <= 2'h0;
			fetch <= 1'b1;
		end else begin
			tick <= tick + 3'h1;
			if (adv) begin
				tst <= tst + 2'h1;
				if (tst == 2'h3) fetch <= ~fetch;
			end
		end
	end
	// status decode, psync only in T1 so none while waiting
	assign psync = (tst == 2'h0);
	assign phase1 = ~tick[2];
	assign m1 = fetch;
	assign dbin = (tst == 2'h1) || (tst == 2'h2);
endmodule

// ==== test/tb_front_panel_step_sequencer.sv ====
// Purpose: self-checking bench for the front panel step sequencer
// Assumes: shortened one-shot counts, processor model on the bus pins
// Notes: deposit bytes and slow periods drawn from a fixed seed
`timescale 1ns/1ps
module tb_front_panel_step_sequencer import fp_pkg::*;;
	localparam logic [31:0] DEB = 32'h32;
	localparam logic [31:0] MWC = 32'ha;
	localparam logic [31:0] SMAX = 32'hc8;
	localparam int XR = 0, RN = 1, SS = 2, DOE = 3, MW = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, low_byte_switches = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, poc_n = 1'b1, bkpt_req = 1'b0;
	logic run_stop_switch = 1'b0, step_switch = 1'b0;
	logic slow_step_switch = 1'b0, examine_switch = 1'b0;
	logic deposit_switch = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, xrdy, run, ss_o, ss_oe;
	logic dbus_oe, mwrite, psync, phase1, m1, dbin;
	logic psync_d = 1'b0;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] dbus_o;
	int err_total = 0, n_compared = 0, psync_n = 0, mw_len = 0;

	front_panel_step_sequencer #(.DEB_CYC(DEB), .MW_CYC(MWC),
		.SLOW_MAX(SMAX)) front_panel_step_sequencer_i (.clk, .rst_n,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .poc_n, .phase1, .psync, .m1, .dbin,
		.bkpt_req, .run_stop_switch, .step_switch, .slow_step_switch,
		.examine_switch, .deposit_switch, .low_byte_switches, .xrdy, .run,
		.ss_o, .ss_oe, .dbus_o, .dbus_oe, .mwrite);
	cpu_model cpu_model_i (.clk, .rst_n, .xrdy, .psync, .phase1, .m1,
		.dbin);

	always #4 clk = ~clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s, got %h expected %h", $time, msg,
				seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("counts: %0d compared, %0d mismatches", n_compared,
			err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hang(input string msg);
		chk(32'h0, 32'h1, msg);
		end_sim();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic pick(input int s);
		case (s)
			XR: return xrdy;
			RN: return run;
			SS: return ss_oe;
			DOE: return dbus_oe;
			default: return mwrite;
		endcase
	endfunction
	// bounded wait for one panel output to reach a level
	task automatic wt(input int s, input logic v);
		int n;
		n = 0;
		while (pick(s) !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 20000) hang("wait ran out");
		end
	endtask
	function automatic logic [31:0] clampp(input logic [31:0] v);
		return (v < DEB) ? DEB : ((v > SMAX) ? SMAX : v);
	endfunction
	// write channels offered together, released as each is taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 100) hang("write answer missing");
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		if (n == 100) hang("read answer missing");
	endtask
	task automatic done(input string s);
		$display("test %s done, %0d mismatches", s, err_total);
	endtask

	// bus watch: driver order, quiet in run, strobe width
	always @(posedge clk) begin
		psync_d <= psync;
		if (psync && !psync_d) psync_n <= psync_n + 1;
		if (dbus_oe === 1'b1) chk(ss_oe, 1'b1, "drivers without ss");
		if (run === 1'b1) chk({ss_oe, mwrite}, 2'h0, "active in run");
		if (ss_oe === 1'b1) chk(ss_o, 1'b0, "ss level");
		if (mwrite === 1'b1) mw_len <= mw_len + 1;
		else if (mw_len != 0) begin
			chk(mw_len, MWC, "strobe width");
			mw_len <= 0;
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] d, v;
		logic [1:0] r;
		logic [7:0] b;
		int p0, gap;
		time t0;
		d = $urandom(32'h9de1);
		cyc(16);
		rst_n <= 1'b1;
		cyc(4);
		axi_rd(STATUS_OFS, d, r);
		chk(d, 32'h0, "status after reset");
		axi_rd(8'h40, d, r);
		chk(r, RESP_SLVERR, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 32'h1 : $urandom % 400;
			axi_wr(SLOW_PERIOD_OFS, v, r);
			axi_rd(SLOW_PERIOD_OFS, d, r);
			chk(d, clampp(v), "slow period clamp");
		end
		done("registers");
		bkpt_req <= 1'b1;
		run_stop_switch <= 1'b1;
		cyc(20);
		chk(run, 1'b0, "run under breakpoint");
		bkpt_req <= 1'b0;
		wt(RN, 1'b1);
		chk(xrdy, 1'b1, "ready in run");
		@(posedge clk) {deposit_switch, step_switch, examine_switch} <= 3'h7;
		cyc(30);
		chk({xrdy, ss_oe, mwrite}, 3'h4, "manual in run");
		{deposit_switch, step_switch, examine_switch} <= 3'h0;
		axi_rd(STATUS_OFS, d, r);
		chk(d, 32'h3, "status in run");
		poc_n <= 1'b0;
		wt(RN, 1'b0);
		chk(xrdy, 1'b0, "clear stops");
		@(posedge clk) poc_n <= 1'b1;
		wt(RN, 1'b1);
		@(posedge clk) run_stop_switch <= 1'b0;
		wt(RN, 1'b0);
		chk({m1, xrdy}, 2'h2, "stop at fetch");
		cyc(40);
		p0 = psync_n;
		cyc(60);
		chk(psync_n - p0, 0, "cycles while stopped");
		done("run_stop");
		@(posedge clk) step_switch <= 1'b1;
		p0 = psync_n;
		wt(XR, 1'b1);
		wt(XR, 1'b0);
		chk(psync_n - p0, 1, "one cycle per step");
		@(posedge clk) step_switch <= 1'b0;
		cyc(4);
		step_switch <= 1'b1;
		cyc(20);
		chk(xrdy, 1'b0, "step during debounce");
		step_switch <= 1'b0;
		axi_wr(CTRL_OFS, 32'h1, r);
		step_switch <= 1'b1;
		cyc(DEB + 20);
		chk(xrdy, 1'b0, "step under lock");
		step_switch <= 1'b0;
		axi_wr(CTRL_OFS, 32'h0, r);
		step_switch <= 1'b1;
		wt(XR, 1'b1);
		wt(XR, 1'b0);
		@(posedge clk) step_switch <= 1'b0;
		done("step");
		cyc(DEB);
		examine_switch <= 1'b1;
		wt(SS, 1'b1);
		chk(xrdy, 1'b1, "examine releases");
		wt(DOE, 1'b1);
		chk(dbus_o, 8'h00, "nop byte");
		wt(SS, 1'b0);
		chk({m1, xrdy, dbus_oe}, 3'h4, "examine end");
		@(posedge clk) examine_switch <= 1'b0;
		done("examine_next");
		for (int i = 0; i < 4; i++) begin
			b = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($urandom));
			low_byte_switches <= b;
			cyc(DEB);
			deposit_switch <= 1'b1;
			wt(SS, 1'b1);
			t0 = $time;
			cyc(5);
			chk(dbus_oe, 1'b0, "drivers late");
			wt(DOE, 1'b1);
			chk(dbus_o, b, "deposit byte");
			wt(MW, 1'b1);
			chk({dbus_oe, xrdy}, 2'h2, "data before strobe");
			wt(DOE, 1'b0);
			gap = ($time - t0) / 8;
			chk(gap >= DEB - 1 && gap <= DEB + 1, 1, "hold time");
			chk({ss_oe, xrdy}, 2'h2, "drivers off first");
			wt(SS, 1'b0);
			@(posedge clk) deposit_switch <= 1'b0;
		end
		done("deposit");
		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? DEB : 60 + $urandom % 141;
			axi_wr(SLOW_PERIOD_OFS, v, r);
			slow_step_switch <= 1'b1;
			wt(XR, 1'b1);
			wt(XR, 1'b0);
			t0 = $time;
			wt(XR, 1'b1);
			wt(XR, 1'b0);
			gap = ($time - t0) / 8;
			chk(gap >= v && gap <= v + 50, 1, "slow period");
			@(posedge clk) slow_step_switch <= 1'b0;
			cyc(SMAX + 20);
		end
		done("slow_step");
		end_sim();
	end
endmodule
